/* File: verilog/jefsc_pkg.sv */
// Shared constants and types of the event flag and start control block.
`default_nettype none
package jefsc_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MSTAT = 8'h04;
    localparam logic [7:0] ADDR_RAW = 8'h08;
    localparam logic [7:0] ADDR_IEN = 8'h0C;
    localparam logic [7:0] ADDR_RUN = 8'h14;
    localparam logic [7:0] ADDR_OPSTAT = 8'h18;
    localparam logic [7:0] ADDR_HUFF = 8'h20;
    localparam logic [7:0] ADDR_FIFOCTL = 8'h40;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_SIZE = 11;
    localparam int BIT_THR = 10;
    localparam int BIT_FULL = 9;
    localparam int BIT_EMPTY = 8;
    localparam int BIT_OVF = 2;
    localparam int BIT_CODEC = 1;
    localparam int BIT_LB = 0;
    localparam int CTRL_MODE = 4;
    localparam int CTRL_SRST = 7;
    localparam int THR_LO = 4;
    localparam int THR_HI = 5;
    localparam int HUFF_AUTO = 0;
    localparam int HUFF_NSTBY = 1;
    localparam int RUN_BIT = 0;
    localparam int OPSTAT_BIT = 0;
    // ------------------------------------------------------------------
    // Reset values, masks and counts
    // ------------------------------------------------------------------
    localparam logic [15:0] IEN_RESET = 16'h0000;
    localparam logic [15:0] IEN_MASK = 16'h0F07;
    localparam logic [15:0] RAW_RESET = 16'h0000;
    localparam logic [1:0] THR_RESET = 2'h0;
    localparam int THR_BYTES = 4;
    // ------------------------------------------------------------------
    // Run control states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ENC_PEND = 3'b001,
        ST_ENC_RUN = 3'b010,
        ST_CAP_PEND = 3'b011,
        ST_CAP_RUN = 3'b100,
        ST_CAP_STOP = 3'b101
    } jefsc_state_t;
endpackage
`default_nettype wire

/* File: verilog/jefsc_top.sv */
// Event flags, interrupt enables and start control with an Avalon slave.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Size violation sets bit 11, encoding continues.
// - Raw flags capture regardless of enables.
// - Write one to masked status clears 11..8.
// - Threshold flag sets once level passes threshold.
// - FIFO full flag latches until cleared.
// - FIFO empty flag latches until cleared.
// - Overflow flag clears only by soft reset.
// - Codec flag clears on operation status read.
// - Line buffer flag clears with its register.
// - Enable register resets zero, seven enable bits.
// - Enable bit 0 gates line buffer interrupts.
// - Overflow interrupt gated only by bit 2.
// - Encode: one starts next frame, zero cancels.
// - Capture: one starts next frame, zero stops.
// - Status raises interrupt only when enabled.
// - Huffman auto bit self clears, blocks table.
module jefsc_top #(
    parameter int FIFO_BYTES = 256,
    parameter int LVL_W = 9
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Avalon-MM slave.
    input wire logic [jefsc_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [jefsc_pkg::DATA_W-1:0] writedata,
    input wire logic [jefsc_pkg::BE_W-1:0] byteenable,
    output logic [jefsc_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    // Event sources.
    input wire logic sizeViolation,
    input wire logic [LVL_W-1:0] fifoLevel,
    input wire logic fifoFull,
    input wire logic fifoEmpty,
    input wire logic lineBufOverflow,
    input wire logic codecIrq,
    input wire logic lineBufIrq,
    input wire logic lineBufFlagClr,
    // Frame and engine status.
    input wire logic frameStart,
    input wire logic frameEnd,
    input wire logic encodeDone,
    input wire logic huffLoadDone,
    // Outputs.
    output logic irq,
    output logic encodeRun,
    output logic captureRun,
    output logic huffBusy,
    output logic huffNonStandby,
    output logic moduleReset,
    output logic [1:0] fifoThrSel
);
    import jefsc_pkg::*;

    // ------------------------------------------------------------------
    // Bus access strobes
    // ------------------------------------------------------------------
    logic [15:0] ienR;
    logic [15:0] rawR;
    logic captureModeR;
    jefsc_state_t stateR;
    jefsc_state_t stateNxt;
    logic wrAcc;
    logic rdAcc;
    logic [15:0] wrMask;
    logic [15:0] wrData;
    logic [15:0] clrW1c;
    logic srstWr;
    logic opRead;
    logic runWr1;
    logic runWr0;
    logic huffSet;
    logic thrNow;
    logic [15:0] rawNxt;
    logic [15:0] rdMux;

    function automatic logic thrHit(input logic [1:0] sel,
                                    input logic [LVL_W-1:0] lvl);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            2'b00: hit = 1'b0;
            2'b01: hit = lvl > LVL_W'(THR_BYTES);
            2'b10: hit = lvl > LVL_W'(FIFO_BYTES / 4);
            2'b11: hit = lvl > LVL_W'(FIFO_BYTES / 2);
        endcase
        return hit;
    endfunction

    // Gates each raw flag by its own enable bit, within IEN_MASK.
    function automatic logic [15:0] gated(input logic [15:0] raw,
                                          input logic [15:0] en);
        logic [15:0] g;
        g = raw & en & IEN_MASK;
        return g;
    endfunction

    // Writes take effect at the edge where waitrequest is seen low.
    assign wrAcc = write && !waitrequest;
    assign rdAcc = read && !waitrequest;
    assign wrMask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    assign wrData = writedata[15:0] & wrMask;
    assign clrW1c = (wrAcc && address == ADDR_MSTAT) ?
                    (wrData & 16'h0F00) : 16'h0000;
    assign srstWr = wrAcc && address == ADDR_CTRL && wrData[CTRL_SRST];
    assign opRead = rdAcc && address == ADDR_OPSTAT;
    assign runWr1 = wrAcc && address == ADDR_RUN && byteenable[0] &&
                    writedata[RUN_BIT];
    assign runWr0 = wrAcc && address == ADDR_RUN && byteenable[0] &&
                    !writedata[RUN_BIT];
    assign huffSet = wrAcc && address == ADDR_HUFF && byteenable[0] &&
                     writedata[HUFF_AUTO] && !captureModeR;
    assign thrNow = thrHit(fifoThrSel, fifoLevel);

    // ------------------------------------------------------------------
    // Raw event flags
    // ------------------------------------------------------------------
    always_comb begin
        rawNxt = RAW_RESET;
        rawNxt[BIT_SIZE] = sizeViolation |
                           (rawR[BIT_SIZE] & ~clrW1c[BIT_SIZE]);
        rawNxt[BIT_THR] = thrNow | (rawR[BIT_THR] & ~clrW1c[BIT_THR]);
        rawNxt[BIT_FULL] = fifoFull | (rawR[BIT_FULL] & ~clrW1c[BIT_FULL]);
        rawNxt[BIT_EMPTY] = fifoEmpty |
                            (rawR[BIT_EMPTY] & ~clrW1c[BIT_EMPTY]);
        rawNxt[BIT_OVF] = lineBufOverflow | (rawR[BIT_OVF] & ~srstWr);
        rawNxt[BIT_CODEC] = codecIrq | (rawR[BIT_CODEC] & ~opRead);
        rawNxt[BIT_LB] = lineBufIrq | (rawR[BIT_LB] & ~lineBufFlagClr);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rawR <= RAW_RESET;
        end else begin
            rawR <= rawNxt;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // enable register write
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ienR <= IEN_RESET;
        end else if (wrAcc && address == ADDR_IEN) begin
            ienR <= (ienR & ~wrMask) | (wrData & IEN_MASK);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            captureModeR <= 1'b0;
            moduleReset <= 1'b0;
            fifoThrSel <= THR_RESET;
        end else begin
            moduleReset <= srstWr;
            if (wrAcc && address == ADDR_CTRL && byteenable[0]) begin
                captureModeR <= writedata[CTRL_MODE];
            end
            if (wrAcc && address == ADDR_FIFOCTL && byteenable[0]) begin
                fifoThrSel <= writedata[THR_HI:THR_LO];
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            huffBusy <= 1'b0;
            huffNonStandby <= 1'b0;
        end else if (huffSet) begin
            huffBusy <= 1'b1;
            huffNonStandby <= writedata[HUFF_NSTBY];
        end else if (huffLoadDone) begin
            huffBusy <= 1'b0;
            huffNonStandby <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    always_comb begin
        stateNxt = stateR;
        unique case (stateR)
            ST_IDLE: begin
                if (runWr1) begin
                    stateNxt = captureModeR ? ST_CAP_PEND : ST_ENC_PEND;
                end
            end
            ST_ENC_PEND: begin
                if (runWr0) begin
                    stateNxt = ST_IDLE;
                end else if (frameStart) begin
                    stateNxt = ST_ENC_RUN;
                end
            end
            ST_ENC_RUN: begin
                if (encodeDone) begin
                    stateNxt = ST_IDLE;
                end
            end
            ST_CAP_PEND: begin
                if (runWr0) begin
                    stateNxt = ST_IDLE;
                end else if (frameStart) begin
                    stateNxt = ST_CAP_RUN;
                end
            end
            ST_CAP_RUN: begin
                if (runWr0) begin
                    stateNxt = ST_CAP_STOP;
                end
            end
            ST_CAP_STOP: begin
                if (runWr1) begin
                    stateNxt = ST_CAP_RUN;
                end else if (frameEnd) begin
                    stateNxt = ST_IDLE;
                end
            end
            default: stateNxt = ST_IDLE;
        endcase
        if (srstWr) begin
            stateNxt = ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stateR <= ST_IDLE;
            encodeRun <= 1'b0;
            captureRun <= 1'b0;
        end else begin
            stateR <= stateNxt;
            encodeRun <= stateNxt == ST_ENC_RUN;
            captureRun <= stateNxt == ST_CAP_RUN ||
                          stateNxt == ST_CAP_STOP;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    // enabled OR
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |gated(rawNxt, ienR);
        end
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    always_comb begin
        unique case (address)
            ADDR_CTRL: rdMux = {11'h000, captureModeR, 4'h0};
            ADDR_MSTAT: rdMux = gated(rawR, ienR);
            ADDR_RAW: rdMux = rawR;
            ADDR_IEN: rdMux = ienR;
            ADDR_OPSTAT: rdMux = {15'h0000, rawR[BIT_CODEC]};
            ADDR_HUFF: rdMux = {15'h0000, huffBusy};
            ADDR_FIFOCTL: rdMux = {10'h000, fifoThrSel, 4'h0};
            default: rdMux = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else if (waitrequest && (read || write)) begin
            waitrequest <= 1'b0;
            readdata <= {16'h0000, read ? rdMux : 16'h0000};
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence encPendStart;
        stateR == ST_ENC_PEND && frameStart && !runWr0 && !srstWr;
    endsequence
    sequence capStopReq;
        stateR == ST_CAP_RUN && runWr0 && !srstWr;
    endsequence
    sequence capFrameDone;
        stateR == ST_CAP_STOP && frameEnd && !runWr1 && !srstWr;
    endsequence

    sizeFlagSet_a: assert property (
        sizeViolation |=> rawR[BIT_SIZE] && $stable(encodeRun))
        else $error("size flag missed or encode disturbed");
    rawNoGate_a: assert property (
        ienR == 16'h0000 && codecIrq |=> rawR[BIT_CODEC] && !irq)
        else $error("raw capture depends on enable");
    w1cClear_a: assert property (
        rawR[BIT_FULL] && clrW1c[BIT_FULL] && !fifoFull
        |=> !rawR[BIT_FULL])
        else $error("write one did not clear full flag");
    thrFlag_a: assert property (
        fifoThrSel == 2'b01 && fifoLevel > LVL_W'(THR_BYTES)
        |=> rawR[BIT_THR])
        else $error("threshold flag not set");
    fullHold_a: assert property (
        rawR[BIT_FULL] && !clrW1c[BIT_FULL] |=> rawR[BIT_FULL])
        else $error("full flag dropped without clear");
    emptyHold_a: assert property (
        fifoEmpty ##1 !clrW1c[BIT_EMPTY] |-> rawR[BIT_EMPTY])
        else $error("empty flag not latched");
    ovfSoftClr_a: assert property (
        rawR[BIT_OVF] && !srstWr |=> rawR[BIT_OVF])
        else $error("overflow flag cleared without soft reset");
    codecRdClr_a: assert property (
        opRead && !codecIrq |=> !rawR[BIT_CODEC])
        else $error("codec flag not cleared by read");
    lbFlagClr_a: assert property (
        lineBufFlagClr && !lineBufIrq |=> !rawR[BIT_LB])
        else $error("line buffer flag not cleared");
    ienWrite_a: assert property (
        wrAcc && address == ADDR_IEN && byteenable == 4'hF
        |=> ienR == ($past(writedata[15:0]) & IEN_MASK))
        else $error("enable register write wrong");
    lbMaster_a: assert property (
        !ienR[BIT_LB] && (gated(rawNxt, ienR) & 16'hFFFE) == 16'h0000
        |=> !irq)
        else $error("line buffer irq passed closed master gate");
    ovfOwnEn_a: assert property (
        ienR[BIT_OVF] && !ienR[BIT_LB] && rawNxt[BIT_OVF] |=> irq)
        else $error("overflow irq blocked by master gate");
    encStart_a: assert property (
        encPendStart |=> encodeRun ##1 (encodeRun || $past(encodeDone)))
        else $error("encode did not start on next frame");
    encCancel_a: assert property (
        stateR == ST_ENC_PEND && runWr0 |=> stateR == ST_IDLE && !encodeRun)
        else $error("pending encode not cancelled");
    capStop_a: assert property (
        capStopReq |=> captureRun ##0 stateR == ST_CAP_STOP)
        else $error("capture stopped before frame end");
    capEnd_a: assert property (
        capFrameDone |=> !captureRun)
        else $error("capture did not stop after frame");
    enableGate_a: assert property (
        (rawNxt & ienR & IEN_MASK) == 16'h0000 |=> !irq)
        else $error("irq without enabled flag");
    irqHold_a: assert property (
        rawR[BIT_SIZE] && ienR[BIT_SIZE] && !clrW1c[BIT_SIZE] |=> irq)
        else $error("irq dropped while enabled flag set");
    huffDone_a: assert property (
        huffBusy && huffLoadDone && !huffSet |=> !huffBusy)
        else $error("auto load bit did not self clear");
    busAnswer_a: assert property (
        waitrequest && (read || write) |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle");
endmodule // jefsc_top
`default_nettype wire

/* File: tb/jefsc_event_model.sv */
// Model of the event sources and FIFO fill level facing the block.
`timescale 1ns/10ps
`default_nettype none
module jefsc_event_model #(
    parameter int LVL_W = 9,
    parameter int FULL_LVL = 256
) (
    // Clock.
    input wire logic core_clk,
    // Event and level requests from the bench.
    input wire logic [8:0] evReq,
    input wire logic [LVL_W-1:0] lvlReq,
    // Event and frame outputs.
    output logic sizeViolation,
    output logic lineBufOverflow,
    output logic codecIrq,
    output logic lineBufIrq,
    output logic lineBufFlagClr,
    output logic frameStart,
    output logic frameEnd,
    output logic encodeDone,
    output logic huffLoadDone,
    // FIFO state.
    output logic [LVL_W-1:0] fifoLevel,
    output logic fifoFull,
    output logic fifoEmpty
);
    logic [8:0] evR = 9'h000;
    logic [LVL_W-1:0] lvlR = 'h1;
    // Events and levels leave the far side on the clock, as the encoder
    // and the FIFO would launch them.
    always @(posedge core_clk) begin
        evR <= evReq;
        lvlR <= lvlReq;
    end
    assign {huffLoadDone, encodeDone, frameEnd, frameStart} = evR[8:5];
    assign {lineBufFlagClr, lineBufIrq, codecIrq} = evR[4:2];
    assign {lineBufOverflow, sizeViolation} = evR[1:0];
    assign fifoLevel = lvlR;
    // Full and empty follow the level, as a real FIFO would.
    assign fifoFull = (lvlR == FULL_LVL);
    assign fifoEmpty = (lvlR == '0);
endmodule // jefsc_event_model
`default_nettype wire

/* File: tb/test_jpeg_event_flags_and_start_control.sv */
// Self-checking bench for the event flag and start control block.
`timescale 1ns/10ps
`default_nettype none
module test_jpeg_event_flags_and_start_control;
    import jefsc_pkg::*;
    localparam int FB = 256;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata, q, v;
    logic waitrequest, irq, encodeRun, captureRun, huffBusy;
    logic huffNonStandby, moduleReset, sizeViolation, lineBufOverflow;
    logic codecIrq, lineBufIrq, lineBufFlagClr, frameStart, frameEnd;
    logic encodeDone, huffLoadDone, fifoFull, fifoEmpty;
    logic [8:0] fifoLevel;
    logic [1:0] fifoThrSel;
    logic [8:0] evReq = 9'h000;
    logic [8:0] lvlReq = 9'h001;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    int bits[4] = '{11, 2, 1, 0};

    jefsc_top #(.FIFO_BYTES(FB), .LVL_W(9)) jefsc_top_inst (
        .core_clk(core_clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .sizeViolation(sizeViolation),
        .fifoLevel(fifoLevel), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty),
        .lineBufOverflow(lineBufOverflow), .codecIrq(codecIrq),
        .lineBufIrq(lineBufIrq), .lineBufFlagClr(lineBufFlagClr),
        .frameStart(frameStart), .frameEnd(frameEnd),
        .encodeDone(encodeDone), .huffLoadDone(huffLoadDone), .irq(irq),
        .encodeRun(encodeRun), .captureRun(captureRun),
        .huffBusy(huffBusy), .huffNonStandby(huffNonStandby),
        .moduleReset(moduleReset), .fifoThrSel(fifoThrSel));

    jefsc_event_model #(.LVL_W(9), .FULL_LVL(FB)) ev (
        .core_clk(core_clk), .evReq(evReq), .lvlReq(lvlReq),
        .sizeViolation(sizeViolation),
        .lineBufOverflow(lineBufOverflow), .codecIrq(codecIrq),
        .lineBufIrq(lineBufIrq), .lineBufFlagClr(lineBufFlagClr),
        .frameStart(frameStart), .frameEnd(frameEnd),
        .encodeDone(encodeDone), .huffLoadDone(huffLoadDone),
        .fifoLevel(fifoLevel), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty));

    always #5 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic int thrLimit(input int sel);
        return (sel == 1) ? 4 : (sel == 2) ? FB / 4 : FB / 2;
    endfunction

    function automatic logic [31:0] expIrq(input logic [15:0] raw,
                                           input logic [15:0] en);
        return {31'h0, |(raw & en & 16'h0F07)};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer; the request stands until waitrequest is low.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [15:0] d, output logic [31:0] r);
        @(posedge core_clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= {16'h0000, d};
        // Only the bench timeout ends a wait that never gets its answer.
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        r = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    // One-cycle pulse on the chosen event line, until the block saw it.
    task automatic pulse(input int idx);
        @(posedge core_clk);
        evReq[idx] <= 1'b1;
        @(posedge core_clk);
        evReq[idx] <= 1'b0;
        @(posedge core_clk);
    endtask

    // New fill level, held until the block has sampled it.
    task automatic setLevel(input logic [8:0] val);
        @(posedge core_clk);
        lvlReq <= val;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h37A48774));
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        bus(0, ADDR_IEN, 16'h0, q);
        chk(q, 32'h0);
        bus(0, ADDR_RAW, 16'h0, q);
        chk(q, 32'h0);
        bus(0, 8'h30, 16'h0, q);
        chk(q, 32'h0);
        bus(0, ADDR_RUN, 16'h0, q);
        chk(q, 32'h0);
        $display("Test reset map done");
        repeat (4) begin
            v = $urandom & 32'h0F07;
            bus(1, ADDR_IEN, v[15:0], q);
            bus(0, ADDR_IEN, 16'h0, q);
            chk(q, v);
        end
        $display("Test enable register done");
        for (int k = 0; k < 4; k++) begin
            bus(1, ADDR_IEN, 16'h0000, q);
            pulse(k);
            bus(0, ADDR_RAW, 16'h0, q);
            chk(q, 32'h1 << bits[k]);
            chk({31'h0, irq}, 32'h0);
            bus(1, ADDR_IEN, 16'h1 << bits[k], q);
            bus(0, ADDR_MSTAT, 16'h0, q);
            chk(q, 32'h1 << bits[k]);
            v = 32'h1 << bits[k];
            chk({31'h0, irq}, expIrq(v[15:0], v[15:0]));
            case (k)
                0: bus(1, ADDR_MSTAT, 16'h0800, q);
                1: begin
                    bus(1, ADDR_CTRL, 16'h0080, q);
                    @(posedge core_clk);
                    chk({31'h0, moduleReset}, 32'h1);
                end
                2: bus(0, ADDR_OPSTAT, 16'h0, q);
                default: pulse(4);
            endcase
            bus(0, ADDR_RAW, 16'h0, q);
            chk(q, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        $display("Test event sources done");
        for (int s = 1; s < 4; s++) begin
            bus(1, ADDR_FIFOCTL, 16'(s << 4), q);
            setLevel(9'(thrLimit(s)));
            chk({30'h0, fifoThrSel}, 32'(s));
            bus(0, ADDR_RAW, 16'h0, q);
            chk(q, 32'h0);
            setLevel(9'(thrLimit(s) + 1 + $urandom_range(0, 2)));
            setLevel(9'h001);
            bus(0, ADDR_RAW, 16'h0, q);
            chk(q, 32'h0400);
            bus(1, ADDR_MSTAT, 16'h0400, q);
            bus(0, ADDR_RAW, 16'h0, q);
            chk(q, 32'h0);
        end
        bus(1, ADDR_FIFOCTL, 16'h0000, q);
        for (int f = 0; f < 2; f++) begin
            setLevel((f == 0) ? 9'(FB) : 9'h000);
            setLevel(9'h001);
            bus(0, ADDR_RAW, 16'h0, q);
            chk(q, 32'h0200 >> f);
            bus(1, ADDR_MSTAT, 16'(16'h0200 >> f), q);
            bus(0, ADDR_RAW, 16'h0, q);
            chk(q, 32'h0);
        end
        $display("Test fifo flags done");
        bus(1, ADDR_CTRL, 16'h0000, q);
        bus(1, ADDR_RUN, 16'h0001, q);
        pulse(5);
        @(negedge core_clk);
        chk({31'h0, encodeRun}, 32'h1);
        pulse(0);
        @(negedge core_clk);
        chk({31'h0, encodeRun}, 32'h1);
        pulse(7);
        @(negedge core_clk);
        chk({31'h0, encodeRun}, 32'h0);
        bus(1, ADDR_RUN, 16'h0001, q);
        bus(1, ADDR_RUN, 16'h0000, q);
        pulse(5);
        @(negedge core_clk);
        chk({31'h0, encodeRun}, 32'h0);
        bus(1, ADDR_MSTAT, 16'h0800, q);
        $display("Test encode control done");
        bus(1, ADDR_CTRL, 16'h0010, q);
        bus(1, ADDR_RUN, 16'h0001, q);
        @(negedge core_clk);
        chk({31'h0, captureRun}, 32'h0);
        pulse(5);
        @(negedge core_clk);
        chk({31'h0, captureRun}, 32'h1);
        bus(1, ADDR_RUN, 16'h0000, q);
        @(negedge core_clk);
        chk({31'h0, captureRun}, 32'h1);
        // A start while stopping resumes, so the frame end is ignored.
        bus(1, ADDR_RUN, 16'h0001, q);
        pulse(6);
        @(negedge core_clk);
        chk({31'h0, captureRun}, 32'h1);
        bus(1, ADDR_RUN, 16'h0000, q);
        pulse(6);
        @(negedge core_clk);
        chk({31'h0, captureRun}, 32'h0);
        $display("Test capture control done");
        bus(1, ADDR_HUFF, 16'h0001, q);
        bus(0, ADDR_HUFF, 16'h0, q);
        chk(q, 32'h0);
        bus(1, ADDR_CTRL, 16'h0000, q);
        bus(1, ADDR_HUFF, 16'h0003, q);
        bus(0, ADDR_HUFF, 16'h0, q);
        chk(q, 32'h1);
        chk({30'h0, huffBusy, huffNonStandby}, 32'h3);
        pulse(8);
        bus(0, ADDR_HUFF, 16'h0, q);
        chk(q, 32'h0);
        chk({31'h0, huffBusy}, 32'h0);
        $display("Test huffman load done");
        give_verdict();
    end
endmodule // test_jpeg_event_flags_and_start_control
`default_nettype wire
